/* hdl/wlf_engine.sv */
// Word list engine: a block of 16-bit words with queue write, shift-down queue
// read and last-entry pop, reached over a plain register port.
// Assumes one clock, a word-indexed register port and an asynchronous start pin.
//
// How it works
// R1 - A queue write first increments the pointer at the list base, then stores the source word at base plus the new pointer.
// R2 - A queue write with the pointer at or above length minus one stores nothing and raises the carry flag.
// R3 - Queue write and read need a length from 2 to 512, else they are skipped with error code 16#200B.
// R4 - A negative pointer skips queue write or read with error code 16#2003.
// R5 - A queue write or read on a list whose last word lies beyond the word block is skipped with error code 16#2003.
// R6 - A queue read decrements the pointer and copies the word at base plus one to the destination.
// R7 - A queue read moves words base plus two up to the last one down by one, the last keeping its value.
// R8 - A queue read or pop with a zero pointer moves no data and raises the zero flag.
// R9 - A pop copies the word at base plus pointer out, clears it, and decrements the pointer.
// R10 - The program normally uses the edge form so one enable change gives one operation.
// R11 - The program may pair queue write and read on one list as producer and consumer.
// R12 - A skipped operation leaves the pointer, the list and the destination untouched.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module wlf_engine
   import wlf_pkg::*;
#(
   parameter int DEPTH = 1024
)
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               ce,
   input  wire logic               op_enable,
   input  wire logic [BUS_AW-1:0]  addr,
   input  wire logic [DATA_W-1:0]  wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output logic      [DATA_W-1:0]  rdata,
   output logic                    busy,
   output logic                    irq
);

   localparam int AW = $clog2(DEPTH);

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_CHECK = 3'b001,
      S_PTR   = 3'b010,
      S_WDATA = 3'b011,
      S_SHIFT = 3'b100,
      S_CLEAR = 3'b101
   } wlf_state_t;

   logic [DATA_W-1:0] mem [DEPTH];
   wlf_state_t        state;
   wlf_op_t           ctrl_op;
   wlf_op_t           op;
   logic              ctrl_edge;
   logic              ctrl_pin;
   logic              go;
   logic [15:0]       reg_base;
   logic [15:0]       reg_len;
   logic [15:0]       reg_xfer;
   logic [ST_W-1:0]   status;
   logic [ST_W-1:0]   mask;
   logic [15:0]       errc;
   logic [15:0]       base;
   logic [15:0]       len;
   logic [15:0]       xfer;
   logic [15:0]       ptr;
   logic [15:0]       data_hold;
   logic [AW-1:0]     idx;
   logic [AW-1:0]     last_idx;
   logic              pin_level;
   logic              pin_rise;
   logic              trigger;
   logic              chk_err;
   logic [15:0]       chk_code;
   logic              chk_full;
   logic              chk_empty;
   logic              skip;
   logic              done;
   logic [ST_W-1:0]   events;
   logic              eng_we;
   logic [AW-1:0]     eng_wa;
   logic [DATA_W-1:0] eng_wd;
   logic [DATA_W-1:0] fetch_ptr;
   logic [DATA_W-1:0] fetch_word;
   logic              reg_hit;
   logic              mem_hit;

   // ----------------------------------------------------------------------
   // Start pin and trigger.
   // ----------------------------------------------------------------------

   wlf_sync_edge u_pin (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .din   (op_enable),
      .level (pin_level),
      .rise  (pin_rise)
   );

   // Edge form fires once per off-to-on change; level form fires every idle cycle.
   assign trigger = go || (ctrl_pin && (ctrl_edge ? pin_rise : pin_level));  // R10

   // ----------------------------------------------------------------------
   // Operand check.
   // ----------------------------------------------------------------------

   // The pointer word is fetched only from inside the block.
   assign fetch_ptr  = ({16'h0000, base} < 32'(DEPTH)) ? mem[AW'(base)] : 16'h0000;
   assign fetch_word = (op == WLF_OP_QWR) ? mem[AW'(xfer)] :
                       (op == WLF_OP_QRD) ? mem[AW'(base + 16'h0001)] :
                       mem[AW'(base + fetch_ptr)];

   wlf_check #(.DEPTH(DEPTH)) u_check (
      .op    (op),
      .base  (base),
      .len   (len),
      .ptr   (fetch_ptr),
      .err   (chk_err),
      .code  (chk_code),
      .full  (chk_full),
      .empty (chk_empty)
   );

   assign skip = chk_err || chk_full || chk_empty;

   // ----------------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------------

   // Operands are copied at start so register writes during a run are harmless.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= S_IDLE;
         op        <= WLF_OP_NONE;
         base      <= 16'h0000;
         len       <= 16'h0000;
         xfer      <= 16'h0000;
         ptr       <= 16'h0000;
         data_hold <= 16'h0000;
         idx       <= '0;
      end else if (ce) begin
         case (state)
            S_IDLE: begin
               if (trigger && ctrl_op != WLF_OP_NONE) begin
                  op    <= ctrl_op;
                  base  <= reg_base;
                  len   <= reg_len;
                  xfer  <= reg_xfer;
                  state <= S_CHECK;
               end
            end
            S_CHECK: begin
               ptr       <= fetch_ptr;
               data_hold <= fetch_word;
               idx       <= AW'(base + 16'h0001);
               if (skip) begin
                  state <= S_IDLE;  // R12
               end else if (op == WLF_OP_POP) begin
                  state <= S_WDATA;
               end else begin
                  state <= S_PTR;
               end
            end
            S_PTR: begin
               state <= (op == WLF_OP_POP) ? S_IDLE : S_WDATA;
            end
            S_WDATA: begin
               if (op == WLF_OP_POP) begin
                  state <= S_CLEAR;
               end else if (op == WLF_OP_QRD && len > LEN_MIN) begin
                  state <= S_SHIFT;
               end else begin
                  state <= S_IDLE;
               end
            end
            S_SHIFT: begin
               idx <= idx + AW'(1);
               if (idx + AW'(1) == last_idx) begin
                  state <= S_IDLE;  // R7
               end
            end
            S_CLEAR: begin
               state <= S_PTR;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   assign last_idx = AW'(base + len - 16'h0001);
   assign busy     = (state != S_IDLE);

   // One pulse at the end of every operation, whether it ran or was skipped.
   assign done = ce && ((state == S_CHECK && skip) ||
                        (state == S_PTR && op == WLF_OP_POP) ||
                        (state == S_WDATA && op == WLF_OP_QWR) ||
                        (state == S_WDATA && op == WLF_OP_QRD && len == LEN_MIN) ||
                        (state == S_SHIFT && idx + AW'(1) == last_idx));

   // ----------------------------------------------------------------------
   // Engine write port into the word block.
   // ----------------------------------------------------------------------
   always_comb begin
      eng_we = 1'b0;
      eng_wa = '0;
      eng_wd = 16'h0000;
      case (state)
         S_PTR: begin
            eng_we = 1'b1;
            eng_wa = AW'(base);
            eng_wd = (op == WLF_OP_QWR) ? ptr + 16'h0001 : ptr - 16'h0001;  // R1 R6 R9
         end
         S_WDATA: begin
            eng_we = 1'b1;
            eng_wa = (op == WLF_OP_QWR) ? AW'(base + ptr + 16'h0001) : AW'(xfer);  // R1
            eng_wd = data_hold;  // R6 R9
         end
         S_SHIFT: begin
            eng_we = 1'b1;
            eng_wa = idx;
            eng_wd = mem[idx + AW'(1)];  // R7
         end
         S_CLEAR: begin
            eng_we = 1'b1;
            eng_wa = AW'(base + ptr);
            eng_wd = 16'h0000;  // R9
         end
         default: begin
            eng_we = 1'b0;
         end
      endcase
   end

   // The engine owns the block while busy; software writes to it are dropped then.
   always_ff @(posedge clk) begin
      if (ce) begin
         if (eng_we) begin
            mem[eng_wa] <= eng_wd;
         end else if (wr && mem_hit && !busy) begin
            mem[AW'(addr)] <= wdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register port.
   // ----------------------------------------------------------------------
   assign mem_hit = addr[MEM_SEL_BIT] && ({17'h00000, addr[MEM_SEL_BIT-1:0]} < 32'(DEPTH));
   assign reg_hit = !addr[MEM_SEL_BIT];

   // Control and operand registers; the go bit is a one-cycle request.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_op   <= wlf_op_t'(CTRL_RESET[CTRL_OP_LSB +: 2]);
         ctrl_edge <= CTRL_RESET[CTRL_EDGE_BIT];
         ctrl_pin  <= CTRL_RESET[CTRL_PIN_BIT];
         go        <= 1'b0;
         reg_base  <= 16'h0000;
         reg_len   <= 16'h0000;
         reg_xfer  <= 16'h0000;
         mask      <= '0;
      end else if (ce) begin
         go <= 1'b0;
         if (wr && reg_hit) begin
            case (addr)
               REG_CTRL: begin
                  ctrl_op   <= wlf_op_t'(wdata[CTRL_OP_LSB +: 2]);
                  ctrl_edge <= wdata[CTRL_EDGE_BIT];
                  ctrl_pin  <= wdata[CTRL_PIN_BIT];
                  go        <= wdata[CTRL_GO_BIT];
               end
               REG_BASE:   reg_base <= wdata;
               REG_LENGTH: reg_len  <= wdata;
               REG_XFER:   reg_xfer <= wdata;
               REG_MASK:   mask     <= wdata[ST_W-1:0];
               default:    go       <= 1'b0;
            endcase
         end
      end
   end

   // Sticky flags; a new event wins over a write-one clear in the same cycle.
   assign events[ST_DONE]  = done;
   assign events[ST_ERROR] = ce && state == S_CHECK && chk_err;
   assign events[ST_CARRY] = ce && state == S_CHECK && !chk_err && chk_full;  // R2
   assign events[ST_ZERO]  = ce && state == S_CHECK && !chk_err && chk_empty;  // R8

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status <= '0;
         errc   <= ERRC_RESET;
      end else if (ce) begin
         status <= (status & ~((wr && addr == REG_STATUS) ? wdata[ST_W-1:0] : '0)) | events;
         if (events[ST_ERROR]) begin
            errc <= chk_code;  // R3 R4 R5
         end
      end
   end

   assign irq = |(status & mask);

   // Read data stand in the cycle after the strobe only.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else if (ce) begin
         rdata <= 16'h0000;
         if (rd && mem_hit) begin
            rdata <= mem[AW'(addr)];
         end else if (rd && reg_hit) begin
            case (addr)
               REG_CTRL:   rdata <= 16'({ctrl_pin, 1'b0, ctrl_edge, ctrl_op});
               REG_BASE:   rdata <= reg_base;
               REG_LENGTH: rdata <= reg_len;
               REG_XFER:   rdata <= reg_xfer;
               REG_STATUS: rdata <= 16'({busy, status});
               REG_MASK:   rdata <= 16'(mask);
               REG_ERRC:   rdata <= errc;
               default:    rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   sequence qw_go_s;
      ce && state == S_CHECK && op == WLF_OP_QWR && !skip;
   endsequence

   sequence pop_go_s;
      ce && state == S_CHECK && op == WLF_OP_POP && !skip;
   endsequence

   qwrite_ptr_a: assert property (@(posedge clk) disable iff (rst)  // R1
      qw_go_s |=> eng_we && eng_wa == AW'(base) && eng_wd == $past(fetch_ptr) + 16'h0001
                  ##1 (!ce || (state == S_WDATA && eng_wa == AW'(base + ptr + 16'h0001))))
      else $error("queue write pointer or slot wrong");

   full_skip_a: assert property (@(posedge clk) disable iff (rst)  // R2
      ce && state == S_CHECK && op == WLF_OP_QWR && !chk_err && chk_full
      |=> state == S_IDLE && status[ST_CARRY] && !eng_we)
      else $error("full list was written");

   length_code_a: assert property (@(posedge clk) disable iff (rst)  // R3
      ce && state == S_CHECK && op != WLF_OP_POP && !fetch_ptr[15]
      && (len < LEN_MIN || len > LEN_MAX) && !(chk_err && chk_code == ERR_RANGE)
      |=> errc == ERR_LENGTH && status[ST_ERROR])
      else $error("length error code wrong");

   negative_ptr_a: assert property (@(posedge clk) disable iff (rst)  // R4
      ce && state == S_CHECK && op != WLF_OP_NONE && fetch_ptr[15]
      |=> errc == ERR_RANGE && state == S_IDLE)
      else $error("negative pointer not refused");

   range_code_a: assert property (@(posedge clk) disable iff (rst)  // R5
      ce && state == S_CHECK && (op == WLF_OP_QWR || op == WLF_OP_QRD)
      && ({1'b0, base} + {1'b0, len} > 17'(DEPTH))
      |=> errc == ERR_RANGE && state == S_IDLE)
      else $error("range overrun not refused");

   qread_copy_a: assert property (@(posedge clk) disable iff (rst)  // R6
      (ce && state == S_CHECK && op == WLF_OP_QRD && !skip) ##1 ce
      |=> eng_wa == AW'(xfer) && eng_wd == $past(mem[AW'(base + 16'h0001)], 2))
      else $error("queue read copied wrong word");

   shift_last_a: assert property (@(posedge clk) disable iff (rst)  // R7
      state == S_SHIFT |-> eng_wa != last_idx && eng_wa > AW'(base))
      else $error("shift touched last or base word");

   empty_skip_a: assert property (@(posedge clk) disable iff (rst)  // R8
      ce && state == S_CHECK && !chk_err && chk_empty
      |=> state == S_IDLE && status[ST_ZERO] && !eng_we)
      else $error("empty list moved data");

   pop_order_a: assert property (@(posedge clk) disable iff (rst)  // R9
      pop_go_s ##1 ce |=> state == S_CLEAR && eng_wd == 16'h0000
                          && eng_wa == AW'(base + ptr))
      else $error("pop did not clear its slot");

   skip_quiet_a: assert property (@(posedge clk) disable iff (rst)  // R12
      ce && state == S_CHECK && skip
      |=> state == S_IDLE && !eng_we && $stable(mem[AW'(base)]))
      else $error("skipped operation wrote words");

endmodule : wlf_engine

/* hdl/wlf_pkg.sv */
// Shared constants of the word list engine: register map, control and status
// fields, operation codes and error codes.
// Assumes a word-indexed plain register port and 16-bit list words.
package wlf_pkg;

   // ----------------------------------------------------------------------
   // Widths.
   // ----------------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int BUS_AW = 16;

   // ----------------------------------------------------------------------
   // Register map, word index on the plain port.
   // ----------------------------------------------------------------------
   localparam logic [15:0] REG_CTRL   = 16'h0000;
   localparam logic [15:0] REG_BASE   = 16'h0001;
   localparam logic [15:0] REG_LENGTH = 16'h0002;
   localparam logic [15:0] REG_XFER   = 16'h0003;
   localparam logic [15:0] REG_STATUS = 16'h0004;
   localparam logic [15:0] REG_MASK   = 16'h0005;
   localparam logic [15:0] REG_ERRC   = 16'h0006;
   localparam int          MEM_SEL_BIT = 15;

   // ----------------------------------------------------------------------
   // Control fields.
   // ----------------------------------------------------------------------
   localparam int CTRL_OP_LSB   = 0;
   localparam int CTRL_EDGE_BIT = 2;
   localparam int CTRL_GO_BIT   = 3;
   localparam int CTRL_PIN_BIT  = 4;
   localparam logic [4:0] CTRL_RESET = 5'h04;

   // ----------------------------------------------------------------------
   // Status fields; bits 0..3 are sticky, bit 4 is live.
   // ----------------------------------------------------------------------
   localparam int ST_DONE  = 0;
   localparam int ST_ERROR = 1;
   localparam int ST_CARRY = 2;
   localparam int ST_ZERO  = 3;
   localparam int ST_BUSY  = 4;
   localparam int ST_W     = 4;

   // ----------------------------------------------------------------------
   // Operations, limits and error codes.
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      WLF_OP_NONE  = 2'b00,
      WLF_OP_QWR   = 2'b01,
      WLF_OP_QRD   = 2'b10,
      WLF_OP_POP   = 2'b11
   } wlf_op_t;

   localparam logic [15:0] LEN_MIN       = 16'h0002;
   localparam logic [15:0] LEN_MAX       = 16'h0200;
   localparam logic [15:0] ERR_RANGE     = 16'h2003;
   localparam logic [15:0] ERR_LENGTH    = 16'h200B;
   localparam logic [15:0] ERRC_RESET    = 16'h0000;

endpackage : wlf_pkg

/* hdl/wlf_sync_edge.sv */
// Two-stage synchroniser with a rising-edge detector behind it.
// Assumes din is asynchronous to clk.
`timescale 1ns/1ps
module wlf_sync_edge
   import wlf_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic din,
   output logic      level,
   output logic      rise
);

   logic meta;
   logic held;

   // ----------------------------------------------------------------------
   // Synchroniser; only the second stage reads the first.
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta  <= 1'b0;
         level <= 1'b0;
         held  <= 1'b0;
      end else if (ce) begin
         meta  <= din;
         level <= meta;
         held  <= level;
      end
   end

   // An off-to-on change of the synchronised level.
   assign rise = level & ~held;

endmodule : wlf_sync_edge

/* hdl/wlf_check.sv */
// Operand checker of the word list engine: range and length errors, full and
// empty decisions for one operation.
// Assumes the pointer word has already been fetched from the list base.
`timescale 1ns/1ps
module wlf_check
   import wlf_pkg::*;
#(
   parameter int DEPTH = 1024
)
(
   input  wlf_op_t     op,
   input  wire logic [15:0] base,
   input  wire logic [15:0] len,
   input  wire logic [15:0] ptr,
   output logic        err,
   output logic [15:0] code,
   output logic        full,
   output logic        empty
);

   localparam logic [16:0] LAST_OK = 17'(DEPTH - 1);

   logic [16:0] last_q;
   logic [16:0] last_p;
   logic        neg;

   // Highest word each operation touches.
   assign last_q = {1'b0, base} + {1'b0, len} - 17'h00001;
   assign last_p = {1'b0, base} + {1'b0, ptr};
   assign neg    = ptr[15];

   // ----------------------------------------------------------------------
   // Error priority: negative pointer, range overrun, then bad length.
   // ----------------------------------------------------------------------
   always_comb begin
      err  = 1'b0;
      code = ERRC_RESET;
      if (op == WLF_OP_POP) begin
         if (neg || last_p > LAST_OK) begin
            err  = 1'b1;
            code = ERR_RANGE;
         end
      end else if (op != WLF_OP_NONE) begin
         if (neg || last_q > LAST_OK) begin  // R4 R5
            err  = 1'b1;
            code = ERR_RANGE;
         end else if (len < LEN_MIN || len > LEN_MAX) begin  // R3
            err  = 1'b1;
            code = ERR_LENGTH;
         end
      end
   end

   // Full compares against the last usable slot; empty is a zero pointer.
   assign full  = (op == WLF_OP_QWR) && (ptr >= len - 16'h0001);  // R2
   assign empty = (op == WLF_OP_QRD || op == WLF_OP_POP) && (ptr == 16'h0000);  // R8

endmodule : wlf_check

/* test/wlf_engine_tb.sv */
// Bench of the word list engine: corner and random list operations, checked
// against a word model kept in the bench.
// Assumes the engine package, the plain register port and a bench-driven clock enable.
`timescale 1ns/1ps
module wlf_engine_tb
   import wlf_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and bench state.
   // ---------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        op_enable = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] rdata;
   logic        busy;
   logic        irq;
   logic [15:0] mdl [0:1023];
   logic [15:0] errc_exp = 16'h0000;
   logic [15:0] got;
   integer      seed = 77082;
   integer      err_total = 0;
   integer      cmp_count = 0;
   integer      tnum = 0;

   // Engine with the full word block; the bench drives the clock enable.
   wlf_engine u_dut (
      .clk(clk), .rst(rst), .ce(ce), .op_enable(op_enable), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .irq(irq));

   // Free-running 125 MHz clock.
   initial begin
      forever #4 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Helpers.
   // ---------------------------------------------------------------
   function automatic int rnd(input int m);
      rnd = int'({1'b0, $random(seed)} % m);
   endfunction : rnd

   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task automatic summarize;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   // One-cycle write strobe, changed just after the edge.
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // One-cycle read strobe; the data stand only in the following cycle.
   task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic wr_mem(input int i, input logic [15:0] d);
      wr_reg({1'b1, 15'(i)}, d);
      mdl[i] = d;
   endtask : wr_mem

   // Expected effect of one operation on the model words and the status.
   task automatic model_op(input wlf_op_t op, input int b, input int n, input int x,
                           output logic [4:0] st);
      int p;
      p  = int'($signed(mdl[b]));
      st = 5'h01;
      if (p < 0 || (op != WLF_OP_POP && b + n - 1 > 1023) ||
          (op == WLF_OP_POP && b + p > 1023)) begin
         st[ST_ERROR] = 1'b1;
         errc_exp = ERR_RANGE;
      end else if (op != WLF_OP_POP && (n < 2 || n > 512)) begin
         st[ST_ERROR] = 1'b1;
         errc_exp = ERR_LENGTH;
      end else if (op == WLF_OP_QWR) begin
         if (p >= n - 1) begin
            st[ST_CARRY] = 1'b1;
         end else begin
            mdl[b] = 16'(p + 1);
            mdl[b + p + 1] = mdl[x];
         end
      end else if (p == 0) begin
         st[ST_ZERO] = 1'b1;
      end else if (op == WLF_OP_QRD) begin
         mdl[b] = 16'(p - 1);
         mdl[x] = mdl[b + 1];
         for (int i = b + 1; i < b + n - 1; i++) mdl[i] = mdl[i + 1];
      end else begin
         mdl[x] = mdl[b + p];
         mdl[b + p] = 16'h0000;
         mdl[b] = 16'(p - 1);
      end
   endtask : model_op

   // Runs one operation by the start bit (0), pin edge (1) or pin level (2), then checks.
   task automatic run_op(input wlf_op_t op, input int b, input int n, input int x,
                         input int pin);
      logic [4:0] st;
      logic [3:0] msk;
      msk = 4'(rnd(16));
      wr_reg(REG_STATUS, 16'h000F);
      wr_reg(REG_MASK, {12'h000, msk});
      rd_reg(REG_MASK, got);
      chk(got, {12'h000, msk}, "mask");
      chk(16'(irq), 16'h0000, "irq clear");
      wr_reg(REG_BASE, 16'(b));
      wr_reg(REG_LENGTH, 16'(n));
      wr_reg(REG_XFER, 16'(x));
      model_op(op, b, n, x, st);
      wr_reg(REG_CTRL, (pin == 0 ? 16'h000C : pin == 1 ? 16'h0014 : 16'h0010) | 16'(op));
      if (pin != 0) begin
         @(posedge clk);
         op_enable <= 1'b1;
      end
      // A one-cycle clock-enable drop before the start must only delay the operation.
      ce <= (rnd(4) != 0);
      @(posedge clk);
      ce <= 1'b1;
      repeat (8) @(posedge clk);
      for (int i = 0; i < 1200 && busy === 1'b1; i++) @(posedge clk);
      if (busy !== 1'b0) begin
         err_total = err_total + 1;
         $display("ERROR %0t engine stays busy", $time);
         summarize();
      end
      repeat (6) @(posedge clk);
      op_enable <= 1'b0;
      // Let a level-form repeat that is still in flight settle.
      repeat (4) @(posedge clk);
      rd_reg(REG_STATUS, got);
      chk(got, {11'h000, st}, "status");
      rd_reg(REG_ERRC, got);
      chk(got, errc_exp, "error code");
      chk(16'(irq), 16'(|(st[3:0] & msk)), "irq level");
      for (int i = 0; i < 64; i++) begin
         rd_reg({1'b1, 15'(i)}, got);
         chk(got, mdl[i], "word");
      end
      tnum = tnum + 1;
      $display("Test %0d done: op %0d base %0d length %0d", tnum, op, b, n);
   endtask : run_op

   // ---------------------------------------------------------------
   // Main sequence: reset values, corner cases, then random traffic.
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] radr [4];
      logic [15:0] rexp [4];
      int          b;
      int          n;
      radr = '{REG_CTRL, REG_STATUS, REG_ERRC, 16'h0007};
      rexp = '{16'h0004, 16'h0000, ERRC_RESET, 16'h0000};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wr_reg(REG_ERRC, 16'h1234);
      wr_reg(16'h0007, 16'hFFFF);
      for (int i = 0; i < 4; i++) begin
         rd_reg(radr[i], got);
         chk(got, rexp[i], "reset value");
      end
      for (int i = 0; i < 64; i++) wr_mem(i, 16'($random(seed)));
      wr_mem(1020, 16'h0000);
      wr_mem(0, 16'h0000);
      run_op(WLF_OP_QWR, 0, 512, 60, 0);
      run_op(WLF_OP_QWR, 0, 513, 60, 0);
      wr_mem(10, 16'h0003);
      run_op(WLF_OP_QRD, 10, 1, 60, 0);
      wr_mem(20, 16'h8000);
      run_op(WLF_OP_QRD, 20, 4, 61, 0);
      run_op(WLF_OP_QWR, 1020, 8, 60, 0);
      wr_mem(30, 16'h0003);
      run_op(WLF_OP_QWR, 30, 4, 62, 0);
      wr_mem(30, 16'h0000);
      run_op(WLF_OP_POP, 30, 4, 62, 0);
      run_op(WLF_OP_QRD, 30, 4, 62, 0);
      run_op(WLF_OP_QWR, 30, 4, 63, 1);
      run_op(WLF_OP_QRD, 10, 1, 60, 2);
      for (int t = 0; t < 40; t++) begin
         b = 2 + rnd(40);
         n = 2 + rnd(7);
         wr_mem(b, 16'(rnd(n)));
         run_op(wlf_op_t'(2'(rnd(3) + 1)), b, n, 56 + rnd(8), rnd(2) == 1);
      end
      summarize();
   end

endmodule : wlf_engine_tb
